/* fmt_unit_regs.svh */
// Constants for the packed decimal and float format unit
`ifndef FMT_UNIT_REGS_SVH
`define FMT_UNIT_REGS_SVH

// Decimal integer memory format
`define DEC_SIGN_BIT 79
`define DEC_DIGITS 7'h12
`define DEC_DIGIT_TOP 7'h11
`define DEC_INDEF 80'hFFFF_C000_0000_0000_0000
`define DEC_MAX_MAG 64'h0DE0_B6B3_A763_FFFF
`define DIGIT_MAX 4'h9

// Binary to decimal shift cycles, one per magnitude bit
`define DABBLE_TOP 7'h3F

// Exponent biases and significand top bit, held at the working exponent width
`define BIAS_HALF 17'h0_000F
`define BIAS_SINGLE 17'h0_007F
`define BIAS_DOUBLE 17'h0_03FF
`define BIAS_EXT 17'h0_3FFF
`define SIG_TOP 17'h0_003F

// Memory footprint in bytes per format
`define BYTES_HALF 4'h2
`define BYTES_SINGLE 4'h4
`define BYTES_DOUBLE 4'h8
`define BYTES_EXT 4'hA

`endif

/* fmt_unit_pkg.sv */
// Types shared by the packed decimal and float format unit
package fmt_unit_pkg;

	typedef enum logic [3:0] {
		OP_LOAD_DEC,
		OP_STORE_DEC,
		OP_UNPK_ADD,
		OP_UNPK_SUB,
		OP_UNPK_MUL,
		OP_UNPK_DIV,
		OP_PACK_ADD,
		OP_PACK_SUB,
		OP_FP_UNPACK
	} op_e;

	typedef enum logic [1:0] {
		FMT_HALF,
		FMT_SINGLE,
		FMT_DOUBLE,
		FMT_EXT
	} fmt_e;

	typedef enum logic [1:0] {
		S_IDLE,
		S_ACC,
		S_NORM,
		S_DABBLE
	} state_e;

	typedef struct packed {
		state_e state;
		op_e op;
		logic sign;
		logic [6:0] cnt;
		logic [63:0] acc;
		logic [71:0] bcd;
		logic err;
		logic indef;
		logic res_valid;
		logic [79:0] res_data;
		logic [3:0] res_bytes;
		logic res_err;
		logic res_indef;
	} state_s;

endpackage

/* fmt_unit_links.sv */
// Carriers between the format unit and its helper modules
`timescale 1ns/1ps

interface norm_if;
	logic [63:0] sig_in;
	logic [5:0] lz;
	logic [63:0] sig_out;
	logic zero;
	modport user(output sig_in, input lz, input sig_out, input zero);
	modport unit(input sig_in, output lz, output sig_out, output zero);
endinterface

interface dig_if;
	logic [3:0] a;
	logic [3:0] b;
	logic sub;
	logic cin;
	logic [3:0] sum;
	logic cout;
	modport user(output a, output b, output sub, output cin, input sum, input cout);
	modport unit(input a, input b, input sub, input cin, output sum, output cout);
endinterface

/* sig_normalizer.sv */
// Leading zero count and left shift of a 64-bit significand
`timescale 1ns/1ps

module sig_normalizer (
	norm_if.unit p
);

	logic found;

	always_comb begin
		found = 1'b0;
		p.lz = 6'h00;
		for (int i = 63; i >= 0; i--) begin
			if (!found && p.sig_in[i]) begin
				p.lz = 6'(63 - i);
				found = 1'b1;
			end
		end
		p.zero = !found;
		p.sig_out = p.sig_in << p.lz;
	end

endmodule // sig_normalizer

/* decimal_digit_unit.sv */
// One decimal digit adder and subtractor with carry or borrow
`timescale 1ns/1ps

module decimal_digit_unit (
	dig_if.unit p
);

	logic [4:0] raw;

	always_comb begin
		if (p.sub) begin
			raw = {1'b0, p.a} - {1'b0, p.b} - {4'h0, p.cin};
			p.cout = raw[4];
			p.sum = raw[4] ? 4'(raw[3:0] + 4'hA) : raw[3:0];
		end else begin
			raw = {1'b0, p.a} + {1'b0, p.b} + {4'h0, p.cin};
			p.cout = raw > 5'h09;
			p.sum = p.cout ? 4'(raw[3:0] + 4'h6) : raw[3:0];
		end
	end

endmodule // decimal_digit_unit

/* decimal_format_unit.sv */
// Packed decimal, digit arithmetic and float unpack datapath
`timescale 1ns/1ps
`include "fmt_unit_regs.svh"

module decimal_format_unit (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic srst_i,
	// Request
	input wire logic req_valid_i,
	output logic req_ready_o,
	input wire fmt_unit_pkg::op_e req_op_i,
	input wire fmt_unit_pkg::fmt_e req_fmt_i,
	input wire logic req_sign_i,
	input wire logic req_inv_masked_i,
	input wire logic [79:0] req_a_i,
	input wire logic [7:0] req_b_i,
	// Result
	output logic res_valid_o,
	output logic [79:0] res_data_o,
	output logic [3:0] res_bytes_o,
	output logic res_err_o,
	output logic res_indef_o
);
	import fmt_unit_pkg::*;

	state_s st;
	state_s next_st;
	logic fire;
	logic [3:0] cur_digit;
	logic [7:0] prod;
	logic fp_sign;
	logic [16:0] fp_field;
	logic [16:0] fp_bias;
	logic [16:0] fp_eff;
	logic [16:0] fp_exp;
	logic [16:0] dec_exp;
	logic [63:0] fp_sig;
	logic [3:0] fp_bytes;
	logic [71:0] shifted;
	logic [71:0] adj;

	norm_if nrm();
	dig_if dig[2]();

	function automatic logic is_digit(input logic [3:0] d);
		is_digit = d <= `DIGIT_MAX;
	endfunction

	// Add three to every digit of five or more before each shift
	function automatic logic [71:0] dabble_adj(input logic [71:0] v);
		logic [71:0] r;
		r = v;
		for (int i = 0; i < 18; i++) begin
			if (r[i*4 +: 4] > 4'h4) begin
				r[i*4 +: 4] = 4'(r[i*4 +: 4] + 4'h3);
			end
		end
		dabble_adj = r;
	endfunction

	sig_normalizer u_norm (
		.p(nrm.unit)
	);

	// Digit chain; the low digit alone serves unpacked operands
	generate
		for (genvar g = 0; g < 2; g++) begin : g_dig
			decimal_digit_unit u_dig (
				.p(dig[g].unit)
			);
			assign dig[g].a = req_a_i[g*4 +: 4];
			assign dig[g].b = req_b_i[g*4 +: 4];
			assign dig[g].sub = (req_op_i == OP_UNPK_SUB) || (req_op_i == OP_PACK_SUB);
			if (g == 0) begin : g_lo
				assign dig[g].cin = 1'b0;
			end else begin : g_hi
				assign dig[g].cin = dig[g-1].cout;
			end
		end
	endgenerate

	assign fire = req_valid_i && (st.state == S_IDLE);
	assign cur_digit = st.bcd[{st.cnt[4:0], 2'b00} +: 4];
	assign prod = {4'h0, req_a_i[3:0]} * {4'h0, req_b_i[3:0]};
	// Named net, since a function result cannot be part-selected
	assign adj = dabble_adj(st.bcd);

	// Float split; implied integer bit rebuilt when exponent nonzero
	always_comb begin
		case (req_fmt_i)
			FMT_HALF: begin
				fp_sign = req_a_i[15];
				fp_field = {12'h000, req_a_i[14:10]};
				fp_bias = `BIAS_HALF;
				fp_sig = {req_a_i[14:10] != 5'h00, req_a_i[9:0], 53'h0};
				fp_bytes = `BYTES_HALF;
			end
			FMT_SINGLE: begin
				fp_sign = req_a_i[31];
				fp_field = {9'h000, req_a_i[30:23]};
				fp_bias = `BIAS_SINGLE;
				fp_sig = {req_a_i[30:23] != 8'h00, req_a_i[22:0], 40'h0};
				fp_bytes = `BYTES_SINGLE;
			end
			FMT_DOUBLE: begin
				fp_sign = req_a_i[63];
				fp_field = {6'h00, req_a_i[62:52]};
				fp_bias = `BIAS_DOUBLE;
				fp_sig = {req_a_i[62:52] != 11'h000, req_a_i[51:0], 11'h000};
				fp_bytes = `BYTES_DOUBLE;
			end
			default: begin
				fp_sign = req_a_i[79];
				fp_field = {2'h0, req_a_i[78:64]};
				fp_bias = `BIAS_EXT;
				fp_sig = req_a_i[63:0];
				fp_bytes = `BYTES_EXT;
			end
		endcase
		fp_eff = (fp_field == 17'h0_0000) ? 17'h0_0001 : fp_field;
		fp_exp = fp_eff - fp_bias + `BIAS_EXT - {11'h000, nrm.lz};
		dec_exp = `BIAS_EXT + `SIG_TOP - {11'h000, nrm.lz};
	end

	// One normalizer is shared; a load in flight has it to itself
	assign nrm.sig_in = (st.state == S_NORM) ? st.acc : fp_sig;

	always_comb begin
		next_st = st;
		next_st.res_valid = 1'b0;
		shifted = 72'h0;
		case (st.state)
			S_IDLE: begin
				if (req_valid_i) begin
					next_st.op = req_op_i;
					next_st.sign = req_sign_i;
					next_st.res_err = 1'b0;
					next_st.res_indef = 1'b0;
					next_st.res_bytes = `BYTES_EXT;
					next_st.res_data = 80'h0;
					next_st.res_valid = 1'b1;
					case (req_op_i)
						OP_LOAD_DEC: begin
							next_st.res_valid = 1'b0;
							next_st.bcd = req_a_i[71:0];
							next_st.sign = req_a_i[`DEC_SIGN_BIT];
							next_st.indef = req_a_i == `DEC_INDEF;
							next_st.acc = 64'h0;
							next_st.err = 1'b0;
							next_st.cnt = `DEC_DIGIT_TOP;
							next_st.state = S_ACC;
						end
						OP_STORE_DEC: begin
							if (req_inv_masked_i || (req_a_i[63:0] > `DEC_MAX_MAG)) begin
								next_st.res_data = `DEC_INDEF;
								next_st.res_indef = 1'b1;
							end else begin
								next_st.res_valid = 1'b0;
								next_st.acc = req_a_i[63:0];
								next_st.bcd = 72'h0;
								next_st.cnt = `DABBLE_TOP;
								next_st.state = S_DABBLE;
							end
						end
						OP_UNPK_ADD, OP_UNPK_SUB: begin
							next_st.res_data[8:0] = {dig[0].cout, 4'h0, dig[0].sum};
							next_st.res_err = !is_digit(req_a_i[3:0]) || !is_digit(req_b_i[3:0]);
						end
						OP_UNPK_MUL: begin
							next_st.res_data[15:0] = {4'h0, 4'(prod / 8'h0A), 4'h0, 4'(prod % 8'h0A)};
							next_st.res_err = (req_a_i[7:4] != 4'h0) || (req_b_i[7:4] != 4'h0)
								|| !is_digit(req_a_i[3:0]) || !is_digit(req_b_i[3:0]);
						end
						OP_UNPK_DIV: begin
							if (req_b_i[3:0] != 4'h0) begin
								next_st.res_data[15:0] = {4'h0, req_a_i[3:0] % req_b_i[3:0],
									4'h0, req_a_i[3:0] / req_b_i[3:0]};
							end
							next_st.res_err = (req_a_i[7:4] != 4'h0) || (req_b_i[7:4] != 4'h0)
								|| (req_b_i[3:0] == 4'h0)
								|| !is_digit(req_a_i[3:0]) || !is_digit(req_b_i[3:0]);
						end
						OP_PACK_ADD, OP_PACK_SUB: begin
							next_st.res_data[8:0] = {dig[1].cout, dig[1].sum, dig[0].sum};
							next_st.res_err = !is_digit(req_a_i[3:0]) || !is_digit(req_a_i[7:4])
								|| !is_digit(req_b_i[3:0]) || !is_digit(req_b_i[7:4]);
						end
						OP_FP_UNPACK: begin
							next_st.res_data = {fp_sign, nrm.zero ? 15'h0000 : fp_exp[14:0],
								nrm.sig_out};
							next_st.res_bytes = fp_bytes;
						end
						default: begin
							next_st.res_err = 1'b1;
						end
					endcase
				end
			end
			S_ACC: begin
				next_st.acc = (st.acc << 3) + (st.acc << 1) + {60'h0, cur_digit};
				if (!is_digit(cur_digit)) begin
					next_st.err = 1'b1;
				end
				next_st.cnt = st.cnt - 7'h01;
				if (st.cnt == 7'h00) begin
					next_st.state = S_NORM;
				end
			end
			S_NORM: begin
				// Exact: eighteen digits need at most sixty bits of significand
				next_st.res_data = {st.sign, nrm.zero ? 15'h0000 : dec_exp[14:0], nrm.sig_out};
				next_st.res_err = st.err;
				next_st.res_indef = st.indef;
				next_st.res_valid = 1'b1;
				next_st.state = S_IDLE;
			end
			S_DABBLE: begin
				shifted = {adj[70:0], st.acc[63]};
				next_st.bcd = shifted;
				next_st.acc = st.acc << 1;
				next_st.cnt = st.cnt - 7'h01;
				if (st.cnt == 7'h00) begin
					next_st.res_data = {st.sign, 7'h00, shifted};
					next_st.res_valid = 1'b1;
					next_st.state = S_IDLE;
				end
			end
			default: begin
				next_st.state = S_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (srst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign req_ready_o = st.state == S_IDLE;
	assign res_valid_o = st.res_valid;
	assign res_data_o = st.res_data;
	assign res_bytes_o = st.res_bytes;
	assign res_err_o = st.res_err;
	assign res_indef_o = st.res_indef;

	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (srst_i);

	property p_bad_digit;
		st.state == S_ACC && cur_digit > 4'h9 |=> st.err;
	endproperty
	a_bad_digit: assert property (p_bad_digit) else $error("bad digit not flagged");

	property p_add_ignores_upper;
		fire && req_op_i == OP_UNPK_ADD && req_a_i[3:0] < 4'hA && req_b_i[3:0] < 4'hA |=> !res_err_o;
	endproperty
	a_add_ignores_upper: assert property (p_add_ignores_upper) else $error("upper nibble used");

	property p_mul_upper;
		fire && req_op_i == OP_UNPK_MUL && req_a_i[7:4] != 4'h0 |=> res_valid_o && res_err_o;
	endproperty
	a_mul_upper: assert property (p_mul_upper) else $error("mul upper nibble accepted");

	property p_pack_carry;
		fire && req_op_i == OP_PACK_ADD && req_a_i[7:0] == 8'h09 && req_b_i[7:0] == 8'h01
			|=> res_data_o[8:0] == 9'h010;
	endproperty
	a_pack_carry: assert property (p_pack_carry) else $error("packed carry wrong");

	property p_store_sign;
		res_valid_o && st.op == OP_STORE_DEC && !res_indef_o |-> res_data_o[79:72] == {st.sign, 7'h00};
	endproperty
	a_store_sign: assert property (p_store_sign) else $error("store sign byte wrong");

	property p_store_indef;
		fire && req_op_i == OP_STORE_DEC && req_inv_masked_i |=> res_valid_o && res_data_o == `DEC_INDEF;
	endproperty
	a_store_indef: assert property (p_store_indef) else $error("indefinite not written");

	property p_load_latency;
		fire && req_op_i == OP_LOAD_DEC |=> !res_valid_o [*8] ##12 res_valid_o;
	endproperty
	a_load_latency: assert property (p_load_latency) else $error("load latency wrong");

	property p_load_norm;
		res_valid_o && st.op == OP_LOAD_DEC && res_data_o[63:0] != 64'h0 |-> res_data_o[63];
	endproperty
	a_load_norm: assert property (p_load_norm) else $error("load not normalized");

	property p_single_bias;
		fire && req_op_i == OP_FP_UNPACK && req_fmt_i == FMT_SINGLE && req_a_i[30:23] == 8'h7F
			|=> res_data_o[78:63] == {15'h3FFF, 1'b1};
	endproperty
	a_single_bias: assert property (p_single_bias) else $error("single bias wrong");

	property p_double_bytes;
		fire && req_op_i == OP_FP_UNPACK && req_fmt_i == FMT_DOUBLE |=> res_bytes_o == 4'h8;
	endproperty
	a_double_bytes: assert property (p_double_bytes) else $error("double size wrong");

	c_load: cover property (res_valid_o && st.op == OP_LOAD_DEC && !res_err_o);
	c_store: cover property (res_valid_o && st.op == OP_STORE_DEC && !res_indef_o);
	c_store_indef: cover property (res_valid_o && res_indef_o && st.op == OP_STORE_DEC);
	c_fp_half: cover property (fire && req_op_i == OP_FP_UNPACK && req_fmt_i == FMT_HALF);

endmodule // decimal_format_unit

/* exec_model.sv */
// Execution-side requester model for the format unit
`timescale 1ns/1ps

module exec_model (
	// Clock
	input wire logic mclk_i,
	// Request
	output logic req_valid_o,
	input wire logic req_ready_i,
	output fmt_unit_pkg::op_e req_op_o,
	output fmt_unit_pkg::fmt_e req_fmt_o,
	output logic req_sign_o,
	output logic req_inv_o,
	output logic [79:0] req_a_o,
	output logic [7:0] req_b_o,
	// Result
	input wire logic res_valid_i,
	input wire logic [79:0] res_data_i,
	input wire logic [3:0] res_bytes_i,
	input wire logic res_err_i,
	input wire logic res_indef_i
);
	import fmt_unit_pkg::*;
	logic [79:0] got_data;
	logic [3:0] got_bytes;
	logic got_err;
	logic got_indef;
	int got_lat;
	initial begin
		req_valid_o = 1'b0;
		req_op_o = OP_LOAD_DEC;
		req_fmt_o = FMT_EXT;
		req_sign_o = 1'b0;
		req_inv_o = 1'b0;
		req_a_o = 80'h0;
		req_b_o = 8'h00;
	end
	// Called just after an edge; held until taken
	task automatic issue(input op_e op, input fmt_e fmt, input logic sg, inv, input logic [79:0] a,
		input logic [7:0] b);
		req_op_o = op;
		req_fmt_o = fmt;
		req_sign_o = sg;
		req_inv_o = inv;
		req_a_o = a;
		req_b_o = b;
		req_valid_o = 1'b1;
		while (req_ready_i !== 1'b1) begin
			@(posedge mclk_i);
			#1;
		end
		@(posedge mclk_i);
		#1;
		req_valid_o = 1'b0;
		// Released operands flip so stale values cannot pass
		req_a_o = ~a;
		req_b_o = ~b;
		got_lat = 1;
		while (res_valid_i !== 1'b1 && got_lat < 200) begin
			@(posedge mclk_i);
			#1;
			got_lat++;
		end
		got_data = res_data_i;
		got_bytes = res_bytes_i;
		got_err = res_err_i;
		got_indef = res_indef_i;
		// One idle edge so a next request never re-raises valid in this step
		@(posedge mclk_i);
		#1;
	endtask
	// Strobe that ignores ready
	task automatic poke();
		req_op_o = OP_UNPK_ADD;
		req_valid_o = 1'b1;
		@(posedge mclk_i);
		#1;
		req_valid_o = 1'b0;
	endtask
endmodule // exec_model

/* testbench.sv */
// Self-checking testbench for the decimal format unit
`timescale 1ns/1ps

module testbench;
	import fmt_unit_pkg::*;
	logic mclk_i, srst_i, req_valid, req_ready, req_sign, req_inv, res_valid, res_err, res_indef;
	op_e req_op;
	fmt_e req_fmt;
	logic [79:0] req_a, res_data;
	logic [7:0] req_b;
	logic [3:0] res_bytes;
	int n_mismatch = 0;
	int compares = 0;
	int n_res = 0;
	decimal_format_unit u_dut (.mclk_i(mclk_i), .srst_i(srst_i), .req_valid_i(req_valid), .req_ready_o(req_ready),
		.req_op_i(req_op), .req_fmt_i(req_fmt), .req_sign_i(req_sign), .req_inv_masked_i(req_inv),
		.req_a_i(req_a), .req_b_i(req_b), .res_valid_o(res_valid), .res_data_o(res_data),
		.res_bytes_o(res_bytes), .res_err_o(res_err), .res_indef_o(res_indef));
	exec_model u_exec (.mclk_i(mclk_i), .req_valid_o(req_valid), .req_ready_i(req_ready), .req_op_o(req_op),
		.req_fmt_o(req_fmt), .req_sign_o(req_sign), .req_inv_o(req_inv), .req_a_o(req_a), .req_b_o(req_b),
		.res_valid_i(res_valid), .res_data_i(res_data), .res_bytes_i(res_bytes), .res_err_i(res_err),
		.res_indef_i(res_indef));
	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) if (res_valid === 1'b1) n_res++;
	task automatic chk(input logic [79:0] g, e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %0t got %0h exp %0h", $time, g, e);
		end
	endtask
	function automatic logic [79:0] ext_of(input logic [79:0] d);
		logic [63:0] m;
		int e;
		m = 64'h0;
		for (int i = 17; i >= 0; i--) m = m * 10 + d[4*i +: 4];
		if (m == 0) return {d[79], 79'h0};
		e = 63;
		while (!m[63]) begin
			m = m << 1;
			e--;
		end
		return {d[79], 15'(16383 + e), m};
	endfunction
	function automatic logic [71:0] bcd_of(input logic [63:0] m);
		logic [71:0] r;
		for (int i = 0; i < 18; i++) begin
			r[4*i +: 4] = 4'(m % 10);
			m = m / 10;
		end
		return r;
	endfunction
	task automatic res(input int lat, input logic [79:0] d, m, input logic [3:0] by, input logic er, ix);
		if (lat != 0) chk(u_exec.got_lat, lat);
		chk(u_exec.got_data & m, d & m);
		chk(u_exec.got_bytes, by);
		chk(u_exec.got_err, er);
		chk(u_exec.got_indef, ix);
	endtask
	task automatic run(input op_e op, input logic [7:0] a, b, input logic [11:0] d, input logic er);
		u_exec.issue(op, FMT_EXT, 1'b0, 1'b0, {72'h0, a}, b);
		res(1, {68'h0, d}, er ? 80'h0 : 80'hFFF, 4'hA, er, 1'b0);
	endtask
	task automatic ld(input logic [79:0] d);
		u_exec.issue(OP_LOAD_DEC, FMT_EXT, 1'b0, 1'b0, d, 8'h00);
		res(20, ext_of(d), '1, 4'hA, 1'b0, 1'b0);
	endtask
	task automatic st(input logic sg, inv, input logic [63:0] m, input int lat);
		logic bad;
		bad = inv || m > 64'h0DE0_B6B3_A763_FFFF;
		u_exec.issue(OP_STORE_DEC, FMT_EXT, sg, inv, {16'h0, m}, 8'h00);
		res(lat, bad ? 80'hFFFF_C000_0000_0000_0000 : {sg, 7'h0, bcd_of(m)}, '1, 4'hA, 1'b0, bad);
	endtask
	task automatic fp(input fmt_e f, input logic [79:0] a, input logic [3:0] by, input logic [79:0] e);
		u_exec.issue(OP_FP_UNPACK, f, 1'b0, 1'b0, a, 8'h00);
		res(1, e, '1, by, 1'b0, 1'b0);
	endtask
	task automatic t_digits();
		run(OP_UNPK_ADD, 8'hF7, 8'h05, 12'h102, 1'b0);
		run(OP_UNPK_ADD, 8'h0B, 8'h01, 12'h000, 1'b1);
		run(OP_UNPK_SUB, 8'h93, 8'hA5, 12'h108, 1'b0);
		run(OP_UNPK_MUL, 8'h07, 8'h08, 12'h506, 1'b0);
		run(OP_UNPK_MUL, 8'h17, 8'h08, 12'h000, 1'b1);
		run(OP_UNPK_DIV, 8'h09, 8'h04, 12'h102, 1'b0);
		run(OP_UNPK_DIV, 8'h09, 8'h00, 12'h000, 1'b1);
		run(OP_PACK_ADD, 8'h58, 8'h47, 12'h105, 1'b0);
		run(OP_PACK_ADD, 8'h09, 8'h01, 12'h010, 1'b0);
		run(OP_PACK_SUB, 8'h12, 8'h34, 12'h178, 1'b0);
		run(OP_PACK_ADD, 8'h1A, 8'h01, 12'h000, 1'b1);
		u_exec.issue(op_e'(4'hF), FMT_EXT, 1'b0, 1'b0, 80'h0, 8'h00);
		res(1, 80'h0, '1, 4'hA, 1'b1, 1'b0);
	endtask
	task automatic t_load();
		ld(80'h8000_0000_0000_0000_0123);
		ld(80'h7F99_9999_9999_9999_9999);
		ld(80'h8000_0000_0000_0000_0000);
		ld(80'h0000_0000_0000_0000_0001);
		ld(80'h0010_0000_0000_0000_0000);
		u_exec.issue(OP_LOAD_DEC, FMT_EXT, 1'b0, 1'b0, 80'hFFFF_C000_0000_0000_0000, 8'h00);
		res(20, 80'h0, 80'h0, 4'hA, 1'b1, 1'b1);
	endtask
	task automatic t_store();
		st(1'b1, 1'b0, 64'h0000_0000_0000_007B, 65);
		st(1'b0, 1'b0, 64'h0DE0_B6B3_A763_FFFF, 65);
		st(1'b1, 1'b0, 64'h0, 65);
		st(1'b0, 1'b1, 64'h0000_0000_0000_007B, 1);
		st(1'b0, 1'b0, 64'h0DE0_B6B3_A764_0000, 1);
	endtask
	task automatic t_float();
		fp(FMT_SINGLE, 80'h4332_2000, 4'h4, {1'b0, 15'h4006, 64'hB220_0000_0000_0000});
		fp(FMT_SINGLE, 80'h3F80_0000, 4'h4, {1'b0, 15'h3FFF, 64'h8000_0000_0000_0000});
		fp(FMT_HALF, 80'hBC00, 4'h2, {1'b1, 15'h3FFF, 64'h8000_0000_0000_0000});
		fp(FMT_DOUBLE, 80'h3FF0_0000_0000_0000, 4'h8, {1'b0, 15'h3FFF, 64'h8000_0000_0000_0000});
		fp(FMT_EXT, 80'h4005_F600_0000_0000_0000, 4'hA, 80'h4005_F600_0000_0000_0000);
		fp(FMT_SINGLE, 80'h0040_0000, 4'h4, {1'b0, 15'h3F80, 64'h8000_0000_0000_0000});
	endtask
	task automatic t_refuse();
		int k;
		k = n_res;
		fork
			u_exec.issue(OP_LOAD_DEC, FMT_EXT, 1'b0, 1'b0, 80'h0000_0000_0000_0000_0042, 8'h00);
			begin
				repeat (3) @(posedge mclk_i);
				#1;
				u_exec.poke();
			end
		join
		repeat (3) @(posedge mclk_i);
		#1;
		chk(n_res - k, 1);
		res(20, ext_of(80'h0000_0000_0000_0000_0042), '1, 4'hA, 1'b0, 1'b0);
	endtask
	task automatic tally_and_finish();
		$display("Comparisons %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		#100_000;
		n_mismatch++;
		tally_and_finish();
	end
	initial begin
		srst_i = 1'b1;
		repeat (2) @(posedge mclk_i);
		#1;
		chk({76'h0, req_ready, res_valid, res_err, res_indef}, {76'h0, 4'b1000});
		chk(res_data, 80'h0);
		srst_i = 1'b0;
		t_digits();
		t_load();
		t_store();
		t_float();
		t_refuse();
		tally_and_finish();
	end
endmodule // testbench
